/* File: logic/eam_regs.vh */
// Offsets, field positions, reset values and timing counts of the error alarm monitor.
`ifndef EAM_REGS_VH
`define EAM_REGS_VH
`define EAM_ADDR_ALARM_MASK 8'h54
`define EAM_ADDR_ALARM_CFG 8'h55
`define EAM_ADDR_SHDN_MASK 8'h56
`define EAM_ADDR_LOG_LO 8'h57
`define EAM_ADDR_LOG_HI 8'h58
`define EAM_ADDR_FIRST 8'h60
`define EAM_ADDR_LATEST 8'h61
`define EAM_ADDR_CUMUL 8'h62
`define EAM_POL_BIT 2
`define EAM_HOLD_LSB 3
`define EAM_HOLD_MSB 5
`define EAM_PULLUP_BIT 2
`define EAM_REACT_BIT 6
`define EAM_EV_LOSS 0
`define EAM_EV_CLIP 1
`define EAM_EV_CTRL_MIN 2
`define EAM_EV_CTRL_MAX 3
`define EAM_EV_EXT 4
`define EAM_EV_TEMP 5
`define EAM_EV_CFG 6
`define EAM_NEV 7
`define EAM_RST_MASK 7'h00
`define EAM_RST_BYTE 8'h00
`define EAM_HOLD_STEP_US 12500
`define EAM_CLK_MHZ 40
`define EAM_HOLD_STEP_CYC (`EAM_HOLD_STEP_US * `EAM_CLK_MHZ)
`endif

/* File: logic/eam_sync.v */
// Two-stage synchroniser for one asynchronous level.
`timescale 1ns/100ps
`default_nettype none
module eam_sync (
	input wire clk,
	input wire rstn,
	input wire d,
	output reg q
);
	reg meta_q;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* File: logic/eam_monitor.v */
// Error alarm monitor: routing masks, alarm pin, driver shutdown, fault log.
// Operation
// - Alarm-masked events toggle the alarm pin state.
// - Shutdown-masked events tristate drivers, lowest LED range.
// - Log-masked events are latched for recording.
// - Loss of signal uses bit zero.
// - Configuration error cannot pull alarm low.
// - Alarm pin is open drain and input.
// - Polarity selects drive on error or idle.
// - Internal errors hold pin minimum coded time.
// - Pull-up bit enables alarm pull-up source.
// - Temperature warning with hysteresis, maskable.
// - Over-temperature shutdown ignores the shutdown mask.
// - Reactivation after errors clear or power-on.
// - First and latest logged error records kept.
// - Cumulative record collects every logged error.
// - Records share log mask bit positions.
// - Outputs tristate during start; fault latches.
// - High voltage on alarm pin enters test.
// - Configuration bus operates as multi-master.
// - Event bit assignment for bits six to zero.
// - Configuration shutdown bit keeps drivers off.
`timescale 1ns/100ps
`default_nettype none
`include "eam_regs.vh"
module eam_monitor #(
	parameter HOLD_STEP_CYC = `EAM_HOLD_STEP_CYC
) (
	input wire clk,
	input wire rstn,
	input wire reg_we,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire start_done,
	input wire below_ground,
	input wire loss_of_signal,
	input wire signal_clipping,
	input wire ctrl_range_min,
	input wire ctrl_range_max,
	input wire config_error,
	input wire temp_above_warn,
	input wire temp_below_hyst,
	input wire temp_above_off,
	input wire alarm_pin_in,
	input wire alarm_pin_test_hv,
	input wire bus_arb_lost,
	output reg alarm_pin_oe,
	output reg alarm_pin_out,
	output reg alarm_pullup_on,
	output reg line_driver_en,
	output reg led_current_min,
	output reg test_mode,
	output reg log_event
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [6:0] alarm_route_mask_q;
	reg [6:0] shutdown_route_mask_q;
	reg [6:0] log_route_mask_q;
	reg alarm_polarity_select_q;
	reg [2:0] alarm_min_hold_time_q;
	reg alarm_pullup_enable_q;
	reg driver_reactivation_mode_q;
	reg [6:0] first_fault_record_q;
	reg [6:0] latest_fault_record_q;
	reg [6:0] cumulative_fault_record_q;
	reg first_seen_q;
	reg temp_warn_q;
	reg start_fault_q;
	reg shut_q;
	reg [2:0] hold_step_q;
	reg [25:0] hold_cnt_q;
	reg alarm_on_q;
	reg [6:0] logged_q;
	reg [1:0] oe_hist_q;
	wire ext_err_s;
	wire test_hv_s;
	wire below_ground_s;
	wire [6:0] events;
	wire [6:0] new_log;
	wire alarm_req;
	wire shut_req;
	wire hold_tick;
	// ----------------------------------------------------------------
	// Synchronisation of pin inputs
	// ----------------------------------------------------------------
	// The external error is the low level on the pin while the device does
	// not pull it; the gating happens after synchronisation.
	eam_sync u_sync_ext (
		.clk(clk),
		.rstn(rstn),
		.d(~alarm_pin_in),
		.q(ext_err_s)
	);
	eam_sync u_sync_test (
		.clk(clk),
		.rstn(rstn),
		.d(alarm_pin_test_hv),
		.q(test_hv_s)
	);
	// The ground monitor is an analog comparator outside the clock domain.
	eam_sync u_sync_gnd (
		.clk(clk),
		.rstn(rstn),
		.d(below_ground),
		.q(below_ground_s)
	);
	// ----------------------------------------------------------------
	// Event vector
	// ----------------------------------------------------------------
	assign events[`EAM_EV_LOSS] = loss_of_signal;
	assign events[`EAM_EV_CLIP] = signal_clipping;
	assign events[`EAM_EV_CTRL_MIN] = ctrl_range_min;
	assign events[`EAM_EV_CTRL_MAX] = ctrl_range_max;
	// The pin only reads an external error while idle with low-active logic.
	// The synchronised level still shows our own pull-down for two cycles
	// after it ends, so those cycles are masked as well.
	assign events[`EAM_EV_EXT] = ext_err_s & ~alarm_pin_oe & ~|oe_hist_q
		& ~alarm_polarity_select_q;
	assign events[`EAM_EV_TEMP] = temp_warn_q;
	assign events[`EAM_EV_CFG] = config_error;
	assign alarm_req = |(events & alarm_route_mask_q);
	assign shut_req = |(events & shutdown_route_mask_q) | temp_above_off
		| start_fault_q | ~start_done;
	assign new_log = events & log_route_mask_q;
	assign hold_tick = (hold_cnt_q == HOLD_STEP_CYC - 1);
	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alarm_route_mask_q <= `EAM_RST_MASK;
			shutdown_route_mask_q <= `EAM_RST_MASK;
			log_route_mask_q <= `EAM_RST_MASK;
			alarm_polarity_select_q <= 1'b0;
			alarm_min_hold_time_q <= 3'h0;
			alarm_pullup_enable_q <= 1'b0;
			driver_reactivation_mode_q <= 1'b0;
		end else if (reg_we) begin
			case (reg_addr)
			`EAM_ADDR_ALARM_MASK: begin
				alarm_route_mask_q <= reg_wdata[6:0];
			end
			`EAM_ADDR_ALARM_CFG: begin
				alarm_polarity_select_q <= reg_wdata[`EAM_POL_BIT];
				alarm_min_hold_time_q <=
					reg_wdata[`EAM_HOLD_MSB:`EAM_HOLD_LSB];
			end
			`EAM_ADDR_SHDN_MASK: begin
				shutdown_route_mask_q <= reg_wdata[6:0];
			end
			`EAM_ADDR_LOG_LO: begin
				log_route_mask_q[3:0] <= reg_wdata[7:4];
				alarm_pullup_enable_q <= reg_wdata[`EAM_PULLUP_BIT];
			end
			`EAM_ADDR_LOG_HI: begin
				log_route_mask_q[6:4] <= reg_wdata[2:0];
				driver_reactivation_mode_q <= reg_wdata[`EAM_REACT_BIT];
			end
			default: begin
			end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Temperature warning, start phase and driver shutdown
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			temp_warn_q <= 1'b0;
			start_fault_q <= 1'b0;
			shut_q <= 1'b1;
			line_driver_en <= 1'b0;
			led_current_min <= 1'b1;
		end else begin
			if (temp_above_warn)
				temp_warn_q <= 1'b1;
			else if (temp_below_hyst)
				temp_warn_q <= 1'b0;
			if (!start_done && below_ground_s)
				start_fault_q <= 1'b1;
			// A power-on-only policy keeps the shutdown until reset;
			// a configuration-error shutdown holds until the configuration error clears.
			if (shut_req)
				shut_q <= 1'b1;
			else if (!driver_reactivation_mode_q
				&& !(config_error && shutdown_route_mask_q[`EAM_EV_CFG]))
				shut_q <= 1'b0;
			line_driver_en <= ~shut_q;
			led_current_min <= shut_q;
		end
	end
	// ----------------------------------------------------------------
	// Alarm indication with minimum hold time
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alarm_on_q <= 1'b0;
			hold_step_q <= 3'h0;
			hold_cnt_q <= 26'h0000000;
		end else if (alarm_req) begin
			alarm_on_q <= 1'b1;
			hold_step_q <= alarm_min_hold_time_q;
			hold_cnt_q <= 26'h0000000;
		end else if (alarm_on_q && hold_step_q == 3'h0) begin
			alarm_on_q <= 1'b0;
		end else if (alarm_on_q) begin
			if (hold_tick) begin
				hold_cnt_q <= 26'h0000000;
				hold_step_q <= hold_step_q - 3'h1;
			end else begin
				hold_cnt_q <= hold_cnt_q + 26'h0000001;
			end
		end
	end
	// ----------------------------------------------------------------
	// Alarm pin drive
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			alarm_pin_oe <= 1'b0;
			alarm_pin_out <= 1'b0;
			alarm_pullup_on <= 1'b0;
			test_mode <= 1'b0;
		end else begin
			alarm_pin_out <= 1'b0;
			if (shut_q || (config_error && !alarm_polarity_select_q))
				alarm_pin_oe <= 1'b0;
			else
				alarm_pin_oe <= alarm_on_q ^ alarm_polarity_select_q;
			alarm_pullup_on <= alarm_pullup_enable_q;
			if (test_hv_s)
				test_mode <= 1'b1;
		end
	end
	// ----------------------------------------------------------------
	// Pin drive history
	// ----------------------------------------------------------------
	// Keeps the last two drive states to match the synchroniser latency.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			oe_hist_q <= 2'b00;
		end else begin
			oe_hist_q <= {oe_hist_q[0], alarm_pin_oe};
		end
	end
	// ----------------------------------------------------------------
	// Fault records
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_fault_record_q <= `EAM_RST_MASK;
			latest_fault_record_q <= `EAM_RST_MASK;
			cumulative_fault_record_q <= `EAM_RST_MASK;
			first_seen_q <= 1'b0;
			logged_q <= `EAM_RST_MASK;
			log_event <= 1'b0;
		end else begin
			logged_q <= new_log;
			log_event <= |(new_log & ~logged_q);
			if (|(new_log & ~logged_q)) begin
				if (!first_seen_q) begin
					first_fault_record_q <= new_log & ~logged_q;
					first_seen_q <= 1'b1;
				end
				latest_fault_record_q <= new_log & ~logged_q;
			end
			// A write loads the written bits, but a new event in that cycle stays set.
			if (reg_we && reg_addr == `EAM_ADDR_CUMUL)
				cumulative_fault_record_q <= reg_wdata[6:0] | new_log;
			else
				cumulative_fault_record_q <=
					cumulative_fault_record_q | new_log;
		end
	end
	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= `EAM_RST_BYTE;
		end else begin
			case (reg_addr)
			`EAM_ADDR_ALARM_MASK: reg_rdata <= {1'b0, alarm_route_mask_q};
			`EAM_ADDR_ALARM_CFG: reg_rdata <= {2'b00, alarm_min_hold_time_q,
				alarm_polarity_select_q, 2'b00};
			`EAM_ADDR_SHDN_MASK: reg_rdata <= {1'b0, shutdown_route_mask_q};
			`EAM_ADDR_LOG_LO: reg_rdata <= {log_route_mask_q[3:0], 1'b0,
				alarm_pullup_enable_q, 2'b00};
			`EAM_ADDR_LOG_HI: reg_rdata <= {1'b0, driver_reactivation_mode_q,
				3'b000, log_route_mask_q[6:4]};
			`EAM_ADDR_FIRST: reg_rdata <= {1'b0, first_fault_record_q};
			`EAM_ADDR_LATEST: reg_rdata <= {1'b0, latest_fault_record_q};
			`EAM_ADDR_CUMUL: reg_rdata <= {1'b0, cumulative_fault_record_q};
			// Arbitration loss shows in the top bit of reads from unmapped addresses.
			default: reg_rdata <= {bus_arb_lost, 7'h00};
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: verif/eam_monitor_checker.sv */
// Concurrent checks on the ports of the error alarm monitor.
`timescale 1ns/100ps
`default_nettype none
module eam_monitor_checker #(
	parameter HOLD_STEP_CYC = 10
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic reg_we,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic start_done,
	input wire logic temp_above_off,
	input wire logic alarm_pin_test_hv,
	input wire logic alarm_pin_oe,
	input wire logic alarm_pin_out,
	input wire logic alarm_pullup_on,
	input wire logic line_driver_en,
	input wire logic led_current_min,
	input wire logic test_mode,
	input wire logic log_event
);
// ----------
// Properties
// ----------
default clocking cb @(posedge clk); endclocking
default disable iff (!rstn);
chk_shut_pin: assert property (!line_driver_en |-> !alarm_pin_oe)
	else $error("alarm pin driven while drivers off");
chk_shut_led: assert property (!line_driver_en |-> led_current_min)
	else $error("led current not at lowest range");
chk_over_temp: assert property ($rose(temp_above_off) |-> ##[1:6] !line_driver_en)
	else $error("no shutdown on over temperature");
chk_start_off: assert property (!start_done |-> ##2 !line_driver_en)
	else $error("drivers on during start phase");
chk_drain_only: assert property (alarm_pin_out == 1'b0)
	else $error("alarm pin driven high");
chk_test_entry: assert property ($rose(alarm_pin_test_hv) |-> ##[1:6] test_mode)
	else $error("test mode not entered");
chk_test_hold: assert property (test_mode |=> test_mode)
	else $error("test mode left without reset");
chk_pullup_wr: assert property (reg_we && reg_addr == 8'h57 |=> ##1
	alarm_pullup_on == $past(reg_wdata[2], 2))
	else $error("pull-up does not follow its bit");
cover property ($fell(line_driver_en));
cover property ($rose(alarm_pin_oe));
cover property (log_event);
cover property ($rose(test_mode));
endmodule
bind eam_monitor eam_monitor_checker #(.HOLD_STEP_CYC(HOLD_STEP_CYC)) u_chk (
	.clk(clk), .rstn(rstn), .reg_we(reg_we), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .start_done(start_done),
	.temp_above_off(temp_above_off), .alarm_pin_test_hv(alarm_pin_test_hv),
	.alarm_pin_oe(alarm_pin_oe), .alarm_pin_out(alarm_pin_out),
	.alarm_pullup_on(alarm_pullup_on), .line_driver_en(line_driver_en),
	.led_current_min(led_current_min), .test_mode(test_mode),
	.log_event(log_event)
);
`default_nettype wire

/* File: verif/eam_plc_model.sv */
// Behavioural system controller on the open-drain alarm line.
`timescale 1ns/100ps
`default_nettype none
module eam_plc_model (
	input wire logic clk,
	input wire logic oe,
	input wire logic pu,
	input wire logic ext,
	output wire logic pin
);
	logic last = 1'b0;
	// An undriven line without pull-up toggles, so a stale level never helps.
	assign pin = (oe | (ext & !oe)) ? 1'b0 : (pu ? 1'b1 : ~last);
	always @(posedge clk) last <= pin;
endmodule
`default_nettype wire

/* File: verif/test_eam_monitor.sv */
// Self-checking bench of the error alarm monitor.
`timescale 1ns/100ps
`default_nettype none
module test_eam_monitor;
	localparam int STEP = 10;
	logic clk = 1'b0, rstn = 1'b0, we = 1'b0, sd = 1'b0, bg = 1'b0;
	logic hy = 1'b0, to = 1'b0, hv = 1'b0, bal = 1'b0;
	logic [7:0] ad = 8'h00, wd = 8'h00, r;
	logic [6:0] ev = 7'h00, m, fst, lst, acc;
	logic [6:0] sq [4] = '{7'h02, 7'h01, 7'h08, 7'h10};
	logic [7:0] ra [8] = '{8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h60, 8'h61, 8'h62};
	wire [7:0] rdo;
	wire oe, out, pu, en, led, tm, le, pin;
	int failures = 0, checks = 0, cyc = 0;
	eam_monitor #(.HOLD_STEP_CYC(STEP)) uut (
		.clk(clk), .rstn(rstn), .reg_we(we), .reg_addr(ad), .reg_wdata(wd),
		.reg_rdata(rdo), .start_done(sd), .below_ground(bg),
		.loss_of_signal(ev[0]), .signal_clipping(ev[1]),
		.ctrl_range_min(ev[2]), .ctrl_range_max(ev[3]), .config_error(ev[6]),
		.temp_above_warn(ev[5]), .temp_below_hyst(hy), .temp_above_off(to),
		.alarm_pin_in(pin), .alarm_pin_test_hv(hv), .bus_arb_lost(bal),
		.alarm_pin_oe(oe), .alarm_pin_out(out), .alarm_pullup_on(pu),
		.line_driver_en(en), .led_current_min(led), .test_mode(tm),
		.log_event(le)
	);
	eam_plc_model plc (.clk(clk), .oe(oe), .pu(pu), .ext(ev[4]), .pin(pin));
	always #12.5 clk = ~clk;
	// ---------------
	// Helpers
	// ---------------
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	function automatic logic exp_oe(input logic pol, input logic err);
		return pol ^ err;
	endfunction
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (e !== s) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			failures++;
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		we <= 1'b1;
		ad <= a;
		wd <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		ad <= a;
		w(2);
		cmp("rdata", e, rdo);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			failures++;
			tally_and_finish;
		end
	end
	// ---------------
	// Scenarios
	// ---------------
	initial begin
		r = 8'h05;
		w(4);
		rstn <= 1'b1;
		w(4);
		cmp("drv_start", 8'h00, en);
		sd <= 1'b1;
		w(6);
		cmp("drv_run", 8'h01, en);
		foreach (ra[i]) rd(ra[i], 8'h00);
		repeat (3) begin
			r = lfsr(r);
			wr(8'h56, r & 8'h7F);
			rd(8'h56, r & 8'h7F);
		end
		wr(8'h56, 8'h00);
		bal <= r[0];
		rd(8'h70, {r[0], 7'h00});
		for (int i = 0; i < 4; i++) begin
			wr(8'h54, 8'h01 << i);
			ev <= 7'h01 << i;
			w(8);
			cmp("alarm_on", exp_oe(0, 1), oe);
			ev <= 7'h00;
			wr(8'h54, 8'h0F ^ (8'h01 << i));
			ev <= 7'h01 << i;
			w(8);
			cmp("alarm_off", exp_oe(0, 0), oe);
			ev <= 7'h00;
		end
		wr(8'h55, 8'h10);
		wr(8'h54, 8'h01);
		ev <= 7'h01;
		w(8);
		ev <= 7'h00;
		w(2 * STEP - 4);
		cmp("hold_on", 8'h01, oe);
		w(14);
		cmp("hold_end", 8'h00, oe);
		wr(8'h55, 8'h04);
		w(4);
		cmp("pol_idle", exp_oe(1, 0), oe);
		ev <= 7'h01;
		w(8);
		cmp("pol_err", exp_oe(1, 1), oe);
		ev <= 7'h00;
		wr(8'h55, 8'h00);
		wr(8'h54, 8'h40);
		ev <= 7'h40;
		w(8);
		cmp("cfg_low", 8'h00, oe);
		wr(8'h56, 8'h40);
		w(6);
		cmp("cfg_shut", 8'h00, en);
		ev <= 7'h00;
		wr(8'h56, 8'h02);
		ev <= 7'h02;
		w(8);
		cmp("shut_drv", 8'h00, en);
		cmp("shut_led", 8'h01, led);
		ev <= 7'h00;
		w(8);
		cmp("react_0", 8'h01, en);
		wr(8'h58, 8'h40);
		ev <= 7'h02;
		w(8);
		ev <= 7'h00;
		w(8);
		cmp("react_1", 8'h00, en);
		rstn <= 1'b0;
		w(2);
		rstn <= 1'b1;
		w(6);
		cmp("react_por", 8'h01, en);
		to <= 1'b1;
		w(8);
		cmp("temp_off", 8'h00, en);
		to <= 1'b0;
		w(8);
		cmp("temp_back", 8'h01, en);
		wr(8'h54, 8'h20);
		ev <= 7'h20;
		w(8);
		cmp("warn_on", 8'h01, oe);
		ev <= 7'h00;
		w(8);
		cmp("warn_hyst", 8'h01, oe);
		hy <= 1'b1;
		w(8);
		cmp("warn_clr", 8'h00, oe);
		hy <= 1'b0;
		wr(8'h57, 8'hA4);
		w(2);
		cmp("pullup", 8'h01, pu);
		wr(8'h58, 8'h01);
		w(4);
		m = {3'h1, 4'hA};
		fst = 7'h00;
		lst = 7'h00;
		acc = 7'h00;
		foreach (sq[i]) begin
			ev <= sq[i];
			w(8);
			ev <= 7'h00;
			w(8);
			if ((sq[i] & m) != 7'h00) begin
				fst = (fst == 7'h00) ? (sq[i] & m) : fst;
				lst = sq[i] & m;
				acc = acc | (sq[i] & m);
			end
		end
		wr(8'h60, 8'h7F);
		rd(8'h60, {1'b0, fst});
		rd(8'h61, {1'b0, lst});
		rd(8'h62, {1'b0, acc});
		hv <= 1'b1;
		w(8);
		cmp("test_mode", 8'h01, tm);
		hv <= 1'b0;
		rstn <= 1'b0;
		sd <= 1'b0;
		bg <= 1'b1;
		w(2);
		rstn <= 1'b1;
		w(6);
		bg <= 1'b0;
		sd <= 1'b1;
		w(8);
		cmp("start_fault", 8'h00, en);
		tally_and_finish;
	end
endmodule
`default_nettype wire
